// File: hw/mcrtc_clock_controller.sv
// Main clock controller: CPU prescaler, clock-out and periodic time base.
// Assumes APB from the CPU side and an oscillator-rate clock; halt and wake
// requests come from logic on the same clock.
//
// How it works
// R1: CPU clock enable from programmable prescaler
// R2: CAN clock ignores prescaler setting
// R3: Clock-out drives oscillator over two
// R4: Clock-out stops in active halt
// R5: Time-base select picks four divide counts
// R6: Selection change waits for period end
// R7: Hardware sets flag; reading register clears
// R8: Control/status resets to 01h
// R9: Upper four status bits read zero
// R10: Software avoids bit set/clear on status
// R11: Halt with irq enable enters active halt
// R12: Irq needs flag, enable, unmasked CPU
// R13: Wait mode leaves time base running
// R14: Active halt counts, registers frozen, wakes
// R15: Full halt freezes all; other wake (canClockEnable stays high in full halt)
// R16: Three functions run independently together
// R17: Normal divides two; slow four to 32
// R18: Clock-out disabled frees pin; resets off
// R19: Counter restarts each period automatically
`timescale 1ns/100ps
module mcrtc_clock_controller #(
   parameter int TB_COUNT_0 = mcrtc_pkg::TB_COUNT_0,
   parameter int TB_COUNT_1 = mcrtc_pkg::TB_COUNT_1,
   parameter int TB_COUNT_2 = mcrtc_pkg::TB_COUNT_2,
   parameter int TB_COUNT_3 = mcrtc_pkg::TB_COUNT_3
) (
   input  wire logic                             clock,
   input  wire logic                             rst,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [mcrtc_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             haltRequest,
   input  wire logic                             wakeRequest,
   input  wire logic                             globalIrqMask,
   output logic                                  cpuClockEnable,
   output logic                                  canClockEnable,
   output logic                                  clockOutPin,
   output logic                                  clockOutDriveEnable,
   output logic                                  timebaseIrqRequest,
   output logic                                  activeHaltMode,
   output logic                                  fullHaltMode,
   output logic                                  irq
);
   logic [7:0]                  csrReg;
   logic [7:0]                  miscReg;
   logic [1:0]                  irqStatus;
   logic [1:0]                  irqMask;
   logic [4:0]                  prescaleCount;
   logic                        clockOutToggle;
   mcrtc_pkg::mcrtc_power_t     mode;
   mcrtc_pkg::mcrtc_power_t     next_mode;

   wire                         timebaseFlag     = csrReg[mcrtc_pkg::CSR_FLAG_BIT];
   wire                         timebaseIrqEnable = csrReg[mcrtc_pkg::CSR_IRQEN_BIT];
   wire [1:0]                   timebaseSelect   = csrReg[mcrtc_pkg::CSR_TBSEL_LSB +: 2];
   wire                         slowModeSelect   = miscReg[mcrtc_pkg::MISC_SLOW_BIT];
   wire [1:0]                   slowClockDivider = miscReg[mcrtc_pkg::MISC_DIV_LSB +: 2];
   wire                         clockOutEnable   = miscReg[mcrtc_pkg::MISC_CLKOUT_BIT];

   // Bus decode
   wire                         hitMisc      = paddr == mcrtc_pkg::MISC_ADDR;
   wire                         hitCsr       = paddr == mcrtc_pkg::CSR_ADDR;
   wire                         hitStatus    = paddr == mcrtc_pkg::IRQ_STATUS_ADDR;
   wire                         hitMask      = paddr == mcrtc_pkg::IRQ_MASK_ADDR;
   wire                         addrHit      = hitMisc || hitCsr || hitStatus || hitMask;
   wire                         setupPhase   = psel && !penable;
   wire                         accessDone   = psel && penable;
   wire                         running      = mode == mcrtc_pkg::MODE_RUN;
   // Registers are frozen outside run mode
   wire                         regWrite     = accessDone && pwrite && addrHit && running;  // see R14 see R15
   wire                         csrReadDone  = accessDone && !pwrite && hitCsr && running;

   // Time base
   wire                         timebaseRun  = mode != mcrtc_pkg::MODE_FULL_HALT;           // see R13 see R15
   wire                         timebaseTick;
   wire [1:0]                   activeSelect;

   mcrtc_timebase_counter #(
      .COUNT_0 (TB_COUNT_0),
      .COUNT_1 (TB_COUNT_1),
      .COUNT_2 (TB_COUNT_2),
      .COUNT_3 (TB_COUNT_3)
   ) u_timebase (
      .clock        (clock),
      .rst          (rst),
      .run          (timebaseRun),
      .select       (timebaseSelect),
      .tick         (timebaseTick),
      .activeSelect (activeSelect)
   );

   // Read data mux; reserved bits of the status register read zero
   wire [7:0]                   csrReadValue = {4'h0, csrReg[3:0]};                         // see R9
   wire [7:0]                   readMux      = hitCsr    ? csrReadValue :
                                               hitMisc   ? miscReg :
                                               hitStatus ? {6'h0, irqStatus} :
                                               hitMask   ? {6'h0, irqMask} : 8'h00;

   // Prescaler
   wire [4:0]                   divideMask   = !slowModeSelect     ? mcrtc_pkg::DIV_NORMAL :  // see R17
                                               slowClockDivider == 2'h0 ? mcrtc_pkg::DIV_4 :
                                               slowClockDivider == 2'h2 ? mcrtc_pkg::DIV_8 :
                                               slowClockDivider == 2'h1 ? mcrtc_pkg::DIV_16 :
                                                                          mcrtc_pkg::DIV_32;
   wire                         prescaleTick = (prescaleCount & divideMask) == divideMask;  // see R1

   // Flag: hardware set wins over the read clear
   wire                         next_flag    = timebaseTick ? 1'b1 :                        // see R7
                                               csrReadDone  ? 1'b0 : timebaseFlag;
   wire [7:0]                   next_csr     = (regWrite && hitCsr) ?
                                               {4'h0, pwdata[3:1], next_flag} :
                                               {csrReg[7:1], next_flag};

   wire [1:0]                   irqEvents    = {(mode != mcrtc_pkg::MODE_RUN) && (next_mode == mcrtc_pkg::MODE_RUN),
                                                timebaseTick};
   wire [1:0]                   irqClear     = (regWrite && hitStatus) ? pwdata[1:0] : 2'h0;

   // Power mode
   always_comb begin
      next_mode = mode;
      case (mode)
         mcrtc_pkg::MODE_RUN: begin
            if (haltRequest) begin
               next_mode = timebaseIrqEnable ? mcrtc_pkg::MODE_ACTIVE_HALT              // see R11
                                             : mcrtc_pkg::MODE_FULL_HALT;
            end
         end
         mcrtc_pkg::MODE_ACTIVE_HALT: begin
            if (timebaseTick || wakeRequest) begin                                     // see R14
               next_mode = mcrtc_pkg::MODE_RUN;
            end
         end
         mcrtc_pkg::MODE_FULL_HALT: begin
            if (wakeRequest) begin                                                     // see R15
               next_mode = mcrtc_pkg::MODE_RUN;
            end
         end
         default: next_mode = mcrtc_pkg::MODE_RUN;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode <= mcrtc_pkg::MODE_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         csrReg  <= mcrtc_pkg::CSR_RESET;                                              // see R8
         miscReg <= mcrtc_pkg::MISC_RESET;                                             // see R18
      end else begin
         csrReg <= next_csr;
         if (regWrite && hitMisc) begin
            miscReg <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irqStatus <= mcrtc_pkg::IRQ_RESET;
         irqMask   <= mcrtc_pkg::IRQ_RESET;
      end else begin
         irqStatus <= (irqStatus & ~irqClear) | irqEvents;
         if (regWrite && hitMask) begin
            irqMask <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (setupPhase && !pwrite) begin
         prdata <= {24'h0, readMux};
      end
   end

   // Prescaler and clock-out run side by side from the same clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prescaleCount  <= 5'h0;
         clockOutToggle <= 1'b0;
      end else begin
         prescaleCount <= prescaleCount + 5'h1;                                        // see R16
         if (!clockOutEnable) begin
            clockOutToggle <= 1'b0;
         end else if (running) begin
            clockOutToggle <= !clockOutToggle;                                         // see R3 see R4
         end
      end
   end

   assign pready              = 1'b1;
   assign pslverr             = accessDone && !addrHit;
   assign cpuClockEnable      = prescaleTick && running;                                // see R1
   assign canClockEnable      = 1'b1;                                                   // see R2
   assign clockOutPin         = clockOutToggle;
   assign clockOutDriveEnable = clockOutEnable;                                         // see R18
   assign timebaseIrqRequest  = timebaseFlag && timebaseIrqEnable && !globalIrqMask;    // see R12
   assign activeHaltMode      = mode == mcrtc_pkg::MODE_ACTIVE_HALT;
   assign fullHaltMode        = mode == mcrtc_pkg::MODE_FULL_HALT;
   assign irq                 = |(irqStatus & irqMask);

   reset_value_a: assert property (@(posedge clock) disable iff (rst)                   // see R8
      $past(rst) |-> csrReg == mcrtc_pkg::CSR_RESET)
      else $error("status register reset value wrong");
   flag_set_a: assert property (@(posedge clock) disable iff (rst)                      // see R7
      timebaseTick |=> timebaseFlag)
      else $error("flag not set by period end");
   read_clear_a: assert property (@(posedge clock) disable iff (rst)                    // see R7
      (csrReadDone && !timebaseTick && !(regWrite && hitCsr)) |=> !timebaseFlag)
      else $error("flag not cleared by read");
   reserved_zero_a: assert property (@(posedge clock) disable iff (rst)                 // see R9
      (setupPhase && !pwrite && hitCsr) |=> prdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");
   active_halt_a: assert property (@(posedge clock) disable iff (rst)                   // see R11
      (running && haltRequest && timebaseIrqEnable) |=> activeHaltMode)
      else $error("halt with irq enable missed active halt");
   full_halt_a: assert property (@(posedge clock) disable iff (rst)                     // see R15
      (fullHaltMode && !wakeRequest) |=> fullHaltMode && $stable(csrReg))
      else $error("full halt left without wake");
   irq_gate_a: assert property (@(posedge clock) disable iff (rst)                      // see R12
      timebaseIrqRequest |-> timebaseFlag && timebaseIrqEnable && !globalIrqMask)
      else $error("irq request without cause");
   clkout_stop_a: assert property (@(posedge clock) disable iff (rst)                   // see R4
      (activeHaltMode && clockOutEnable) |=> $stable(clockOutPin))
      else $error("clock-out toggled in active halt");
   clkout_run_a: assert property (@(posedge clock) disable iff (rst)                    // see R3
      (running && clockOutEnable) |=> clockOutPin != $past(clockOutPin))
      else $error("clock-out not toggling");
   normal_div_a: assert property (@(posedge clock) disable iff (rst)                    // see R17
      (prescaleTick && !slowModeSelect) |=> !prescaleTick)
      else $error("normal mode prescaler not halving");
   tick_wake_a: assert property (@(posedge clock) disable iff (rst)                     // see R14
      (activeHaltMode && timebaseTick) |=> running ##0 timebaseFlag)
      else $error("tick did not wake active halt");

   tick_seen_c:   cover property (@(posedge clock) disable iff (rst) timebaseTick);
   read_clear_c:  cover property (@(posedge clock) disable iff (rst) csrReadDone && timebaseFlag);
   ahalt_wake_c:  cover property (@(posedge clock) disable iff (rst) activeHaltMode ##1 running);
   fhalt_wake_c:  cover property (@(posedge clock) disable iff (rst) fullHaltMode && wakeRequest);
endmodule

// File: hw/mcrtc_pkg.sv
// Constants, register map and types of the main clock controller with time base.
// Assumes a 32-bit APB master and one oscillator-rate clock.
package mcrtc_pkg;
   localparam int          APB_ADDR_W       = 12;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  MISC_INDEX       = 8'h20;
   localparam logic [7:0]  CSR_INDEX        = 8'h29;
   localparam logic [7:0]  IRQ_STATUS_INDEX = 8'h30;
   localparam logic [7:0]  IRQ_MASK_INDEX   = 8'h31;
   localparam logic [11:0] MISC_ADDR        = {2'h0, MISC_INDEX, 2'h0};
   localparam logic [11:0] CSR_ADDR         = {2'h0, CSR_INDEX, 2'h0};
   localparam logic [11:0] IRQ_STATUS_ADDR  = {2'h0, IRQ_STATUS_INDEX, 2'h0};
   localparam logic [11:0] IRQ_MASK_ADDR    = {2'h0, IRQ_MASK_INDEX, 2'h0};

   localparam logic [7:0]  CSR_RESET        = 8'h01;
   localparam logic [7:0]  MISC_RESET       = 8'h00;
   localparam logic [1:0]  IRQ_RESET        = 2'h0;

   // Control/status field positions
   localparam int          CSR_FLAG_BIT     = 0;
   localparam int          CSR_IRQEN_BIT    = 1;
   localparam int          CSR_TBSEL_LSB    = 2;
   // Misc control one field positions
   localparam int          MISC_SLOW_BIT    = 0;
   localparam int          MISC_DIV_LSB     = 1;
   localparam int          MISC_CLKOUT_BIT  = 5;
   // Interrupt status bits
   localparam int          IRQ_TICK_BIT     = 0;
   localparam int          IRQ_WAKE_BIT     = 1;

   // Oscillator cycles per time-base period
   localparam int          TB_COUNT_0       = 32000;
   localparam int          TB_COUNT_1       = 64000;
   localparam int          TB_COUNT_2       = 160000;
   localparam int          TB_COUNT_3       = 400000;
   localparam int          TB_CNT_W         = 19;

   // Prescaler divide masks (divide ratio minus one)
   localparam logic [4:0]  DIV_NORMAL       = 5'h01;
   localparam logic [4:0]  DIV_4            = 5'h03;
   localparam logic [4:0]  DIV_8            = 5'h07;
   localparam logic [4:0]  DIV_16           = 5'h0f;
   localparam logic [4:0]  DIV_32           = 5'h1f;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_ACTIVE_HALT,
      MODE_FULL_HALT
   } mcrtc_power_t;
endpackage

// File: hw/mcrtc_timebase_counter.sv
// Periodic time-base counter on the oscillator clock.
// Assumes the enclosing controller gates it with a run level.
`timescale 1ns/100ps
module mcrtc_timebase_counter #(
   parameter int COUNT_0 = mcrtc_pkg::TB_COUNT_0,
   parameter int COUNT_1 = mcrtc_pkg::TB_COUNT_1,
   parameter int COUNT_2 = mcrtc_pkg::TB_COUNT_2,
   parameter int COUNT_3 = mcrtc_pkg::TB_COUNT_3
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [1:0] select,
   output logic            tick,
   output logic [1:0]      activeSelect
);
   logic [mcrtc_pkg::TB_CNT_W-1:0] count;
   logic [mcrtc_pkg::TB_CNT_W-1:0] next_count;

   function automatic logic [mcrtc_pkg::TB_CNT_W-1:0] lastCount(input logic [1:0] sel);
      int n;
      case (sel)
         2'h0:    n = COUNT_0;
         2'h1:    n = COUNT_1;
         2'h2:    n = COUNT_2;
         default: n = COUNT_3;
      endcase
      return mcrtc_pkg::TB_CNT_W'(n - 1);
   endfunction

   // New selection is picked up only where a period ends
   assign tick       = run && (count == '0);                              // see R7
   assign next_count = tick ? lastCount(select) : count - 1'b1;            // see R6 see R19

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count        <= mcrtc_pkg::TB_CNT_W'(COUNT_0 - 1);
         activeSelect <= 2'h0;
      end else if (run) begin                                              // see R14 see R15
         count <= next_count;
         if (tick) begin
            activeSelect <= select;                                        // see R6
         end
      end
   end

   period_load_a: assert property (@(posedge clock) disable iff (rst)      // see R5
      tick |=> count == lastCount($past(select)))
      else $error("time-base period not loaded from selection");
   period_hold_a: assert property (@(posedge clock) disable iff (rst)      // see R6
      (run && !tick) |=> $stable(activeSelect))
      else $error("time-base selection changed mid period");
endmodule

// File: verif/mcrtc_cpu_model.sv
// CPU-side and external-device model facing the main clock controller.
// Assumes one oscillator-rate clock; tasks are called just after a rising edge.
`timescale 1ns/100ps
module mcrtc_cpu_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic clockOutPin,
   input  wire logic clockOutDriveEnable,
   output logic      haltRequest,
   output logic      wakeRequest,
   output logic      globalIrqMask
);
   int   clockOutEdges = 0;
   logic lastPin       = 1'b0;

   initial begin
      haltRequest = 1'b0;
      wakeRequest = 1'b0;
      globalIrqMask = 1'b0;
   end

   // External device counts rising edges only while the pin is driven
   always @(posedge clock) begin
      lastPin <= clockOutPin;
      if (!rst && clockOutDriveEnable && clockOutPin && !lastPin) begin
         clockOutEdges <= clockOutEdges + 1;
      end
   end

   // One-cycle pulse, as the halt instruction gives
   task automatic pulseHalt;
      haltRequest <= 1'b1;
      @(posedge clock);
      haltRequest <= 1'b0;
   endtask

   task automatic pulseWake;
      wakeRequest <= 1'b1;
      @(posedge clock);
      wakeRequest <= 1'b0;
   endtask

   task automatic setMask(input logic v);
      globalIrqMask <= v;
   endtask
endmodule

// File: verif/tb_main_clock_rtc_timebase.sv
// Self-checking bench for the main clock controller with time base.
// Assumes the partner model drives halt, wake and the CPU interrupt mask.
`timescale 1ns/100ps
module tb_main_clock_rtc_timebase;
   localparam int N0 = 20, N1 = 40, N2 = 100, N3 = 250;
   logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, haltRequest, wakeRequest, globalIrqMask, cpuClockEnable, canClockEnable;
   logic        clockOutPin, clockOutDriveEnable, timebaseIrqRequest, activeHaltMode, fullHaltMode, irq;
   logic        rerr, p;
   logic [7:0]  m;
   logic [7:0]  mv [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
   int          bad_count = 0, total_checks = 0, cyc = 0, seed = 70107;
   int          k, n, t0, t1, t2, old, e0;

   mcrtc_clock_controller #(.TB_COUNT_0(N0), .TB_COUNT_1(N1), .TB_COUNT_2(N2), .TB_COUNT_3(N3))
   mcrtc_clock_controller_inst (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .haltRequest(haltRequest), .wakeRequest(wakeRequest), .globalIrqMask(globalIrqMask),
      .cpuClockEnable(cpuClockEnable), .canClockEnable(canClockEnable), .clockOutPin(clockOutPin),
      .clockOutDriveEnable(clockOutDriveEnable), .timebaseIrqRequest(timebaseIrqRequest),
      .activeHaltMode(activeHaltMode), .fullHaltMode(fullHaltMode), .irq(irq));

   mcrtc_cpu_model mcrtc_cpu_model_inst (.clock(clock), .rst(rst), .clockOutPin(clockOutPin),
      .clockOutDriveEnable(clockOutDriveEnable), .haltRequest(haltRequest), .wakeRequest(wakeRequest),
      .globalIrqMask(globalIrqMask));

   always #5 clock = ~clock;

   function automatic int divOf(input logic [7:0] v);
      if (!v[0]) return 2;
      case (v[2:1])
         2'b00: return 4;
         2'b10: return 8;
         2'b01: return 16;
         default: return 32;
      endcase
   endfunction

   function automatic int perOf(input int s);
      case (s)
         0: return N0;
         1: return N1;
         2: return N2;
         default: return N3;
      endcase
   endfunction

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      total_checks++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // Setup cycle, then access held until pready is seen high at an edge
   task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
      apbXfer(1'b1, a, d);
   endtask

   task automatic rdReg(input logic [11:0] a);
      apbXfer(1'b0, a, 32'h0);
   endtask

   task automatic waitReq(output int t);
      int w = 0;
      while (timebaseIrqRequest !== 1'b1 && w < 600) begin
         @(posedge clock);
         w++;
      end
      t = cyc;
   endtask

   // Non-blocking so that every reader after an edge sees the same count
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check(clockOutDriveEnable === 1'b0 && clockOutPin === 1'b0, "clock out idle");
      rdReg(mcrtc_pkg::CSR_ADDR);
      check(rdata === 32'h01, "csr reset value");
      rdReg(mcrtc_pkg::CSR_ADDR);
      check(rdata === 32'h00, "flag cleared by read");
      rdReg(mcrtc_pkg::MISC_ADDR);
      check(rdata === 32'h00, "misc reset value");
      rdReg(12'h3fc);
      check(rerr === 1'b1 && rdata === 32'h0, "unmapped read");
      wrReg(12'h3f8, 32'hff);
      check(rerr === 1'b1, "unmapped write");
      // Whole-value writes only on csr, never read-modify-write
      wrReg(mcrtc_pkg::CSR_ADDR, 32'hf2);
      rdReg(mcrtc_pkg::CSR_ADDR);
      check(rdata[31:1] === 31'h01, "csr reserved bits");
      foreach (mv[i]) begin
         m = (mv[i] & 8'h07) | (8'($random(seed)) & 8'hf8);
         wrReg(mcrtc_pkg::MISC_ADDR, {24'h0, m});
         rdReg(mcrtc_pkg::MISC_ADDR);
         check(rdata === {24'h0, m}, "misc readback");
         k = 0;
         repeat (64) begin
            @(posedge clock);
            if (cpuClockEnable === 1'b1) k++;
         end
         check(k == 64 / divOf(m), "cpu clock rate");
         check(canClockEnable === 1'b1, "can clock");
      end
      wrReg(mcrtc_pkg::MISC_ADDR, 32'h21);
      e0 = mcrtc_cpu_model_inst.clockOutEdges;
      k = 0;
      repeat (32) begin
         @(posedge clock);
         if (cpuClockEnable === 1'b1) k++;
      end
      check(clockOutDriveEnable === 1'b1 && mcrtc_cpu_model_inst.clockOutEdges - e0 == 16, "clock out");
      check(k == 8, "prescaler beside clock out");
      wrReg(mcrtc_pkg::CSR_ADDR, 32'h02);
      rdReg(mcrtc_pkg::CSR_ADDR);
      waitReq(t0);
      rdReg(mcrtc_pkg::CSR_ADDR);
      old = 0;
      for (int s = 0; s < 4; s++) begin
         wrReg(mcrtc_pkg::CSR_ADDR, {28'h0, 2'(s), 2'b10});
         waitReq(t1);
         rdReg(mcrtc_pkg::CSR_ADDR);
         check(t1 - t0 == perOf(old), "running period kept");
         waitReq(t2);
         rdReg(mcrtc_pkg::CSR_ADDR);
         check(t2 - t1 == perOf(s), "period length");
         old = s;
         t0 = t2;
      end
      waitReq(t0);
      for (int i = 0; i < 4; i++) begin
         m = 8'($random(seed));
         mcrtc_cpu_model_inst.setMask(m[0]);
         wrReg(mcrtc_pkg::CSR_ADDR, {28'h0, 2'h3, m[1], 1'b0});
         check(timebaseIrqRequest === (m[1] & ~m[0]), "irq request gating");
      end
      mcrtc_cpu_model_inst.setMask(1'b0);
      wrReg(mcrtc_pkg::CSR_ADDR, 32'h0e);
      rdReg(mcrtc_pkg::CSR_ADDR);
      waitReq(t0);
      rdReg(mcrtc_pkg::IRQ_STATUS_ADDR);
      check(rdata[0] === 1'b1, "tick status set");
      wrReg(mcrtc_pkg::IRQ_MASK_ADDR, 32'h3);
      check(irq === 1'b1, "irq raised");
      wrReg(mcrtc_pkg::IRQ_MASK_ADDR, 32'h0);
      check(irq === 1'b0, "irq masked");
      wrReg(mcrtc_pkg::IRQ_STATUS_ADDR, 32'h1);
      rdReg(mcrtc_pkg::IRQ_STATUS_ADDR);
      check(rdata[0] === 1'b0, "tick status cleared");
      rdReg(mcrtc_pkg::CSR_ADDR);
      wrReg(mcrtc_pkg::MISC_ADDR, 32'h20);
      mcrtc_cpu_model_inst.pulseHalt();
      @(posedge clock);
      check(activeHaltMode === 1'b1 && fullHaltMode === 1'b0, "active halt entry");
      p = clockOutPin;
      k = 0;
      repeat (8) begin
         @(posedge clock);
         if (clockOutPin !== p || cpuClockEnable !== 1'b0) k++;
      end
      check(k == 0, "clocks stopped in active halt");
      n = 0;
      while (activeHaltMode !== 1'b0 && n < 400) begin
         @(posedge clock);
         n++;
      end
      check(n <= N3, "tick wakes active halt");
      rdReg(mcrtc_pkg::IRQ_STATUS_ADDR);
      check(rdata[1:0] === 2'b11, "wake and tick status");
      wrReg(mcrtc_pkg::CSR_ADDR, 32'h0c);
      mcrtc_cpu_model_inst.pulseHalt();
      @(posedge clock);
      check(fullHaltMode === 1'b1 && activeHaltMode === 1'b0, "full halt entry");
      wrReg(mcrtc_pkg::MISC_ADDR, 32'h00);
      repeat (300) @(posedge clock);
      check(fullHaltMode === 1'b1, "tick cannot end full halt");
      mcrtc_cpu_model_inst.pulseWake();
      @(posedge clock);
      check(fullHaltMode === 1'b0, "wake ends full halt");
      rdReg(mcrtc_pkg::MISC_ADDR);
      check(rdata === 32'h20, "registers frozen in halt");
      complete_run();
   end
endmodule
